// ==== rtl/irq_vector_logic.sv ====
// interrupt flags, masking, vectoring, return and wake-up for the core
//
// Operation
// - twelve sources, each with flag and enable
// - flags set regardless of any enable
// - global enable bit 7 gates all interrupts
// - flag, enable and global enable take interrupt
// - reset clears the global enable
// - return instruction pops address, sets global enable
// - taking clears global enable, pushes, vectors 0004h
// - peripheral flags gated by peripheral enable bit
// - external event latency three or four cycles; taken on the third boundary, so two-cycle instructions double it
// - edge pin polarity chosen by bit 6
// - ext pin enable bit 4 gates its flag
// - enabled pin event wakes; vector only if enabled
// - timer0 rollover sets bit 2, enable bit 5
// - upper port pins change sets bit 0
// - only the return address is saved
`timescale 1ns/1ps

module irq_vector_logic
	import irq_vector_pkg::*;
#(
	parameter int PERIPH_A_BITS = 8,
	parameter int PERIPH_B_BITS = 1,
	parameter int STACK_DEPTH   = 8,
	parameter int PC_WIDTH      = 13
) (
	input  wire logic                     SYS_CLK,
	input  wire logic                     RESET_N,
	input  wire logic                     CLK_EN,
	// register bus
	input  wire logic [9:0]               AVS_ADDRESS,
	input  wire logic                     AVS_READ,
	input  wire logic                     AVS_WRITE,
	input  wire logic [31:0]              AVS_WRITEDATA,
	output logic      [31:0]              AVS_READDATA,
	output logic                          AVS_WAITREQUEST,
	// event sources
	input  wire logic                     EXT_IRQ_PIN,
	input  wire logic [7:0]               TIMER0_COUNT,
	input  wire logic [3:0]               UPPER_PORT_PINS,
	input  wire logic [PERIPH_A_BITS-1:0] PERIPH_EVENT_A,
	input  wire logic [PERIPH_B_BITS-1:0] PERIPH_EVENT_B,
	// core side
	input  wire logic                     INSTR_BOUNDARY,
	input  wire logic                     RETURN_FROM_IRQ_INSTR,
	input  wire logic [PC_WIDTH-1:0]      RETURN_PC,
	input  wire logic                     SLEEP_ENTER,
	output logic                          IRQ_REQ,
	output logic                          PC_LOAD,
	output logic      [PC_WIDTH-1:0]      PC_LOAD_VALUE,
	output logic                          WAKE,
	output logic                          SLEEPING,
	output logic                          IRQ
);

	localparam int SP_W = $clog2(STACK_DEPTH);
	////////////////////////////////////////////////////////////////////////////////
	// elaboration checks

	generate
		if (PERIPH_A_BITS < 1 || PERIPH_A_BITS > 8 || PERIPH_B_BITS < 1 || PERIPH_B_BITS > 8) begin : g_bad_width
			$error("peripheral register width must be 1 to 8");
		end
		if (3 + PERIPH_A_BITS + PERIPH_B_BITS > SOURCE_COUNT) begin : g_bad_count
			$error("more sources than the controller serves");
		end
		if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_bad_stack
			$error("stack depth must be a power of two");
		end
		if (PC_WIDTH < 13 || PC_WIDTH > 16) begin : g_bad_pc
			$error("program counter width must be 13 to 16");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// state

	logic [7:0]               ctrl_r;
	logic [7:0]               option_r;
	logic [PERIPH_A_BITS-1:0] pflag_a_r;
	logic [PERIPH_B_BITS-1:0] pflag_b_r;
	logic [PERIPH_A_BITS-1:0] pen_a_r;
	logic [PERIPH_B_BITS-1:0] pen_b_r;
	logic [EV_BITS-1:0]       ev_status_r;
	logic [EV_BITS-1:0]       ev_mask_r;
	logic [PC_WIDTH-1:0]      stack_r [STACK_DEPTH];
	logic [SP_W-1:0]          sp_r;
	logic                     ext_prev_r;
	logic [7:0]               tmr_prev_r;
	logic [3:0]               port_prev_r;
	logic                     primed_r;
	logic                     wait_r;
	logic [31:0]              rdata_r;
	logic                     irq_req_r;
	logic                     pc_load_r;
	logic [PC_WIDTH-1:0]      pc_value_r;
	logic                     wake_r;
	logic                     sleeping_r;
	logic                     ext_en_at_sleep_r;
	logic                     irq_r;
	logic [1:0]               boundary_cnt_r;

	////////////////////////////////////////////////////////////////////////////////
	// bus decode

	logic [7:0] idx;
	logic       acc;
	logic       wr_now;
	logic       wr_ctrl;
	logic       wr_opt;
	logic       wr_pfa;
	logic       wr_pfb;
	logic       wr_pea;
	logic       wr_peb;
	logic       wr_evs;
	logic       wr_evm;
	logic [7:0] wd;

	assign idx     = AVS_ADDRESS[9:2];
	assign acc     = (AVS_READ || AVS_WRITE) && !wait_r;
	assign wr_now  = AVS_WRITE && !wait_r;
	assign wd      = AVS_WRITEDATA[7:0];
	assign wr_ctrl = wr_now && idx == IDX_IRQ_CONTROL;
	assign wr_opt  = wr_now && idx == IDX_TIMER_EDGE_OPT;
	assign wr_pfa  = wr_now && idx == IDX_PERIPH_FLAG_A;
	assign wr_pfb  = wr_now && idx == IDX_PERIPH_FLAG_B;
	assign wr_pea  = wr_now && idx == IDX_PERIPH_ENABLE_A;
	assign wr_peb  = wr_now && idx == IDX_PERIPH_ENABLE_B;
	assign wr_evs  = wr_now && idx == IDX_EVENT_STATUS;
	assign wr_evm  = wr_now && idx == IDX_EVENT_MASK;

	////////////////////////////////////////////////////////////////////////////////
	// event detection

	logic ext_edge;
	logic tmr_roll;
	logic port_change;

	// no edge until a real sample is held: reset values would fake a change
	assign ext_edge    = primed_r && (option_r[EXT_EDGE_SELECT_BIT] ? (EXT_IRQ_PIN && !ext_prev_r)
	                                                               : (!EXT_IRQ_PIN && ext_prev_r));
	assign tmr_roll    = tmr_prev_r == TIMER0_TOP && TIMER0_COUNT == TIMER0_BOTTOM;
	assign port_change = primed_r && UPPER_PORT_PINS != port_prev_r;

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ext_prev_r  <= 1'b0;
			tmr_prev_r  <= 8'h00;
			port_prev_r <= 4'h0;
			primed_r    <= 1'b0;
		end else if (CLK_EN) begin
			ext_prev_r  <= EXT_IRQ_PIN;
			tmr_prev_r  <= TIMER0_COUNT;
			port_prev_r <= UPPER_PORT_PINS;
			primed_r    <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// request and take

	logic core_any;
	logic periph_any;
	logic wake_cond;
	logic irq_req;
	logic take;

	assign core_any   = (ctrl_r[TIMER0_ROLLOVER_FLAG_BIT] && ctrl_r[TIMER0_ROLLOVER_ENABLE_BIT])
	                 || (ctrl_r[EXT_PIN_FLAG_BIT] && ctrl_r[EXT_PIN_ENABLE_BIT])
	                 || (ctrl_r[PORT_CHANGE_FLAG_BIT] && ctrl_r[PORT_CHANGE_ENABLE_BIT]);
	assign periph_any = ctrl_r[PERIPH_IRQ_ENABLE_BIT]
	                 && (|(pflag_a_r & pen_a_r) || |(pflag_b_r & pen_b_r));
	assign irq_req    = ctrl_r[GLOBAL_IRQ_ENABLE_BIT] && (core_any || periph_any);
	// pin wake needs the enable that stood when sleep began
	assign wake_cond  = (ctrl_r[EXT_PIN_FLAG_BIT] && ext_en_at_sleep_r)
	                 || (ctrl_r[TIMER0_ROLLOVER_FLAG_BIT] && ctrl_r[TIMER0_ROLLOVER_ENABLE_BIT])
	                 || (ctrl_r[PORT_CHANGE_FLAG_BIT] && ctrl_r[PORT_CHANGE_ENABLE_BIT])
	                 || periph_any;
	// counted in instruction boundaries, so two-cycle instructions double the wait in cycles
	assign take       = irq_req && !sleeping_r && INSTR_BOUNDARY && !RETURN_FROM_IRQ_INSTR
	                 && boundary_cnt_r == 2'(TAKE_BOUNDARIES - 1);

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			boundary_cnt_r <= 2'd0;
		end else if (CLK_EN) begin
			if (!irq_req || sleeping_r || take) begin
				boundary_cnt_r <= 2'd0;
			end else if (INSTR_BOUNDARY && boundary_cnt_r != 2'(TAKE_BOUNDARIES - 1)) begin
				boundary_cnt_r <= boundary_cnt_r + 2'd1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// irq_control_reg

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl_r <= IRQ_CONTROL_RESET;
		end else if (CLK_EN) begin
			if (wr_ctrl) begin
				ctrl_r <= wd;
			end
			if (take) begin
				ctrl_r[GLOBAL_IRQ_ENABLE_BIT] <= 1'b0;
			end else if (RETURN_FROM_IRQ_INSTR) begin
				ctrl_r[GLOBAL_IRQ_ENABLE_BIT] <= 1'b1;
			end
			// flags set whatever the enables say; set wins over the write
			if (tmr_roll) begin
				ctrl_r[TIMER0_ROLLOVER_FLAG_BIT] <= 1'b1;
			end
			if (ext_edge) begin
				ctrl_r[EXT_PIN_FLAG_BIT] <= 1'b1;
			end
			if (port_change) begin
				ctrl_r[PORT_CHANGE_FLAG_BIT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			option_r <= OPTION_RESET;
		end else if (CLK_EN && wr_opt) begin
			option_r <= wd;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// peripheral flags and enables, one cell per bit

	generate
		for (genvar i = 0; i < PERIPH_A_BITS; i++) begin : g_pa
			always_ff @(posedge SYS_CLK or negedge RESET_N) begin
				if (!RESET_N) begin
					pflag_a_r[i] <= PERIPH_REG_RESET[i];
					pen_a_r[i]   <= PERIPH_REG_RESET[i];
				end else if (CLK_EN) begin
					if (PERIPH_EVENT_A[i]) begin
						pflag_a_r[i] <= 1'b1;
					end else if (wr_pfa) begin
						pflag_a_r[i] <= wd[i];
					end
					if (wr_pea) begin
						pen_a_r[i] <= wd[i];
					end
				end
			end
		end
		for (genvar i = 0; i < PERIPH_B_BITS; i++) begin : g_pb
			always_ff @(posedge SYS_CLK or negedge RESET_N) begin
				if (!RESET_N) begin
					pflag_b_r[i] <= PERIPH_REG_RESET[i];
					pen_b_r[i]   <= PERIPH_REG_RESET[i];
				end else if (CLK_EN) begin
					if (PERIPH_EVENT_B[i]) begin
						pflag_b_r[i] <= 1'b1;
					end else if (wr_pfb) begin
						pflag_b_r[i] <= wd[i];
					end
					if (wr_peb) begin
						pen_b_r[i] <= wd[i];
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// return stack: holds the return address only, nothing else

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sp_r       <= '0;
			pc_load_r  <= 1'b0;
			pc_value_r <= '0;
			for (int k = 0; k < STACK_DEPTH; k++) begin
				stack_r[k] <= '0;
			end
		end else if (CLK_EN) begin
			pc_load_r <= 1'b0;
			if (take) begin
				// overflow wraps and overwrites the oldest entry, as the core's stack does
				stack_r[sp_r] <= RETURN_PC;
				sp_r          <= sp_r + 1'b1;
				pc_load_r     <= 1'b1;
				pc_value_r    <= PC_WIDTH'(IRQ_VECTOR);
			end else if (RETURN_FROM_IRQ_INSTR) begin
				sp_r       <= sp_r - 1'b1;
				pc_load_r  <= 1'b1;
				pc_value_r <= stack_r[sp_r - 1'b1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// power-down and wake

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sleeping_r        <= 1'b0;
			ext_en_at_sleep_r <= 1'b0;
			wake_r            <= 1'b0;
		end else if (CLK_EN) begin
			wake_r <= 1'b0;
			if (sleeping_r) begin
				if (wake_cond) begin
					sleeping_r <= 1'b0;
					wake_r     <= 1'b1;
				end
			end else if (SLEEP_ENTER) begin
				sleeping_r        <= 1'b1;
				ext_en_at_sleep_r <= ctrl_r[EXT_PIN_ENABLE_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// event status, mask and interrupt output

	logic [EV_BITS-1:0] ev_set;
	assign ev_set = {RETURN_FROM_IRQ_INSTR && !take, sleeping_r && wake_cond, take};

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ev_status_r <= '0;
			ev_mask_r   <= '0;
			irq_r       <= 1'b0;
			irq_req_r   <= 1'b0;
		end else if (CLK_EN) begin
			// a new event outranks the write-one clear
			ev_status_r <= (wr_evs ? (ev_status_r & ~wd[EV_BITS-1:0]) : ev_status_r) | ev_set;
			if (wr_evm) begin
				ev_mask_r <= wd[EV_BITS-1:0];
			end
			irq_r     <= |(ev_status_r & ev_mask_r);
			irq_req_r <= irq_req;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus slave: one wait cycle, then the answer

	logic [31:0] rdata_nxt;
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (idx == IDX_IRQ_CONTROL) begin
			rdata_nxt[7:0] = ctrl_r;
		end else if (idx == IDX_TIMER_EDGE_OPT) begin
			rdata_nxt[7:0] = option_r;
		end else if (idx == IDX_PERIPH_FLAG_A) begin
			rdata_nxt[PERIPH_A_BITS-1:0] = pflag_a_r;
		end else if (idx == IDX_PERIPH_FLAG_B) begin
			rdata_nxt[PERIPH_B_BITS-1:0] = pflag_b_r;
		end else if (idx == IDX_PERIPH_ENABLE_A) begin
			rdata_nxt[PERIPH_A_BITS-1:0] = pen_a_r;
		end else if (idx == IDX_PERIPH_ENABLE_B) begin
			rdata_nxt[PERIPH_B_BITS-1:0] = pen_b_r;
		end else if (idx == IDX_EVENT_STATUS) begin
			rdata_nxt[EV_BITS-1:0] = ev_status_r;
		end else if (idx == IDX_EVENT_MASK) begin
			rdata_nxt[EV_BITS-1:0] = ev_mask_r;
		end else if (idx == IDX_CORE_STATE) begin
			rdata_nxt[SP_W+1:0] = {sp_r, irq_req_r, sleeping_r};
		end
	end

	// unmapped addresses read zero and ignore writes
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wait_r  <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end else if (CLK_EN) begin
			if (acc) begin
				wait_r <= 1'b1;
			end else if (AVS_READ || AVS_WRITE) begin
				wait_r  <= 1'b0;
				rdata_r <= rdata_nxt;
			end
		end
	end

	assign AVS_READDATA    = rdata_r;
	assign AVS_WAITREQUEST = wait_r;
	assign IRQ_REQ         = irq_req_r;
	assign PC_LOAD         = pc_load_r;
	assign PC_LOAD_VALUE   = pc_value_r;
	assign WAKE            = wake_r;
	assign SLEEPING        = sleeping_r;
	assign IRQ             = irq_r;

endmodule

// ==== shared/irq_vector_pkg.sv ====
// constants for the interrupt flag and vector logic
package irq_vector_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_IRQ_CONTROL     = 8'h0b;
	localparam logic [7:0] IDX_PERIPH_FLAG_A   = 8'h0c;
	localparam logic [7:0] IDX_PERIPH_FLAG_B   = 8'h0d;
	localparam logic [7:0] IDX_TIMER_EDGE_OPT  = 8'h81;
	localparam logic [7:0] IDX_PERIPH_ENABLE_A = 8'h8c;
	localparam logic [7:0] IDX_PERIPH_ENABLE_B = 8'h8d;
	localparam logic [7:0] IDX_EVENT_STATUS    = 8'h90;
	localparam logic [7:0] IDX_EVENT_MASK      = 8'h91;
	localparam logic [7:0] IDX_CORE_STATE      = 8'h92;

	// irq_control_reg fields
	localparam int GLOBAL_IRQ_ENABLE_BIT      = 7;
	localparam int PERIPH_IRQ_ENABLE_BIT      = 6;
	localparam int TIMER0_ROLLOVER_ENABLE_BIT = 5;
	localparam int EXT_PIN_ENABLE_BIT         = 4;
	localparam int PORT_CHANGE_ENABLE_BIT     = 3;
	localparam int TIMER0_ROLLOVER_FLAG_BIT   = 2;
	localparam int EXT_PIN_FLAG_BIT           = 1;
	localparam int PORT_CHANGE_FLAG_BIT       = 0;

	// timer_and_edge_options fields
	localparam int EXT_EDGE_SELECT_BIT = 6;

	// event status / mask fields
	localparam int EV_TAKEN_BIT  = 0;
	localparam int EV_WAKE_BIT   = 1;
	localparam int EV_RETURN_BIT = 2;
	localparam int EV_BITS       = 3;

	// reset values
	localparam logic [7:0] IRQ_CONTROL_RESET  = 8'h00;
	localparam logic [7:0] OPTION_RESET       = 8'hff;
	localparam logic [7:0] PERIPH_REG_RESET   = 8'h00;

	// vector and counter values
	localparam logic [7:0]  TIMER0_TOP       = 8'hff;
	localparam logic [7:0]  TIMER0_BOTTOM    = 8'h00;
	localparam logic [12:0] IRQ_VECTOR       = 13'h0004;
	localparam int          TAKE_BOUNDARIES  = 3;
	localparam int          SOURCE_COUNT     = 12;

endpackage

// ==== verification/irq_vector_asserts.sv ====
// port-level assertions for the interrupt flag and vector logic
`timescale 1ns/1ps

module irq_vector_asserts
	import irq_vector_pkg::*;
#(
	parameter int PC_WIDTH = 13
) (
	input wire logic                SYS_CLK,
	input wire logic                RESET_N,
	input wire logic                AVS_READ,
	input wire logic                AVS_WRITE,
	input wire logic                AVS_WAITREQUEST,
	input wire logic                RETURN_FROM_IRQ_INSTR,
	input wire logic                IRQ_REQ,
	input wire logic                PC_LOAD,
	input wire logic [PC_WIDTH-1:0] PC_LOAD_VALUE,
	input wire logic                WAKE,
	input wire logic                SLEEPING
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);
	////////////////////////////////////////////////////////////////////////////////
	// clock enable is held high by the bench, so no stretching here
	property p_bus_ack;
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
	endproperty
	a_bus_ack: assert property (p_bus_ack) else $error("bus answer not a single cycle");
	property p_reset_quiet;
		$rose(RESET_N) |-> !IRQ_REQ [*3];
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("request right after reset");
	property p_take_vector;
		PC_LOAD && !$past(RETURN_FROM_IRQ_INSTR) |-> PC_LOAD_VALUE == IRQ_VECTOR;
	endproperty
	a_take_vector: assert property (p_take_vector) else $error("take loaded wrong vector");
	property p_take_blocks;
		PC_LOAD && PC_LOAD_VALUE == IRQ_VECTOR |=> !IRQ_REQ;
	endproperty
	a_take_blocks: assert property (p_take_blocks) else $error("request stays after take");
	// slow core: one boundary every other cycle, so twelve cycles covers six, twice the three needed
	property p_latency;
		$rose(IRQ_REQ) && !SLEEPING |-> ##[1:12] (PC_LOAD || !IRQ_REQ || SLEEPING);
	endproperty
	a_latency: assert property (p_latency) else $error("interrupt not taken in time");
	property p_return_load;
		RETURN_FROM_IRQ_INSTR && !IRQ_REQ |=> PC_LOAD;
	endproperty
	a_return_load: assert property (p_return_load) else $error("return did not load pc");
	property p_wake_pulse;
		WAKE |-> !SLEEPING && ($past(SLEEPING) || $past(SLEEPING, 2));
	endproperty
	a_wake_pulse: assert property (p_wake_pulse) else $error("wake without leaving sleep");
	property p_no_take_asleep;
		SLEEPING |=> !(PC_LOAD && PC_LOAD_VALUE == IRQ_VECTOR);
	endproperty
	a_no_take_asleep: assert property (p_no_take_asleep) else $error("take while sleeping");
endmodule

bind irq_vector_logic irq_vector_asserts #(.PC_WIDTH(PC_WIDTH)) chk (
	.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .RETURN_FROM_IRQ_INSTR(RETURN_FROM_IRQ_INSTR), .IRQ_REQ(IRQ_REQ),
	.PC_LOAD(PC_LOAD), .PC_LOAD_VALUE(PC_LOAD_VALUE), .WAKE(WAKE), .SLEEPING(SLEEPING)
);

// ==== verification/core_model.sv ====
// core model: instruction boundaries, return and sleep pulses
`timescale 1ns/1ps

module core_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic slow,
	input  wire logic sleeping,
	input  wire logic ret_cmd,
	input  wire logic sleep_cmd,
	output logic      boundary,
	output logic      ret_pulse,
	output logic      sleep_pulse
);
	logic phase_r;
	////////////////////////////////////////////////////////////////////////////////
	// slow: two-cycle instructions; no boundaries while asleep, the clock is off
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_r  <= 1'b0;
			boundary <= 1'b0;
		end else begin
			phase_r  <= slow ? !phase_r : 1'b0;
			boundary <= (!slow || phase_r) && !sleeping;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ret_pulse   <= 1'b0;
			sleep_pulse <= 1'b0;
		end else begin
			ret_pulse   <= ret_cmd;
			sleep_pulse <= sleep_cmd;
		end
	end
endmodule

// ==== verification/testbench.sv ====
// self-checking bench for the interrupt flag and vector logic
`timescale 1ns/1ps

module testbench
	import irq_vector_pkg::*;
;
	logic        clk, rst_n, rd, wr, wreq, ext_pin, pb, bnd, ret, slp, slow, ret_cmd, sleep_cmd;
	logic        irq_req, pcl, wake, sleeping, irq;
	logic [9:0]  addr;
	logic [31:0] wdata, rdata;
	logic [7:0]  t0, pa;
	logic [3:0]  port;
	logic [12:0] rpc, pcv;
	logic [7:0]  rd_q[$];
	logic [12:0] pc_q[$];
	int          err_total, num_checks, k;
	logic [7:0]  ri[9] = '{8'h0b, 8'h0c, 8'h0d, 8'h81, 8'h8c, 8'h8d, 8'h90, 8'h91, 8'h3f};
	logic [7:0]  rv[9] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	////////////////////////////////////////////////////////////////////////////////
	irq_vector_logic dut (
		.SYS_CLK(clk), .RESET_N(rst_n), .CLK_EN(1'b1), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .EXT_IRQ_PIN(ext_pin),
		.TIMER0_COUNT(t0), .UPPER_PORT_PINS(port), .PERIPH_EVENT_A(pa), .PERIPH_EVENT_B(pb),
		.INSTR_BOUNDARY(bnd), .RETURN_FROM_IRQ_INSTR(ret), .RETURN_PC(rpc), .SLEEP_ENTER(slp),
		.IRQ_REQ(irq_req), .PC_LOAD(pcl), .PC_LOAD_VALUE(pcv), .WAKE(wake), .SLEEPING(sleeping), .IRQ(irq)
	);
	core_model core (.clk(clk), .rst_n(rst_n), .slow(slow), .sleeping(sleeping), .ret_cmd(ret_cmd),
		.sleep_cmd(sleep_cmd), .boundary(bnd), .ret_pulse(ret), .sleep_pulse(slp));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic lvl(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// for reads d is the expected value; the extra edge keeps raises apart
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		addr  <= {idx, 2'b00};
		wdata <= {24'h0, d};
		rd    <= !w;
		wr    <= w;
		if (!w) rd_q.push_back(d);
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		if (wreq !== 1'b0) err_total++;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic drain();
		int n;
		n = 0;
		while (pc_q.size() != 0 && n < 40) begin
			@(posedge clk);
			n++;
		end
		lvl(pc_q.size() == 0, 1'b1);
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (rd && wreq === 1'b0) chk(rdata, {24'h0, rd_q.pop_front()});
		if (pcl === 1'b1) chk({19'h0, pcv}, pc_q.size() == 0 ? 32'hbad : {19'h0, pc_q.pop_front()});
	end
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (4000) @(posedge clk);
		err_total++;
		complete_run();
	end
	initial begin
		{rst_n, rd, wr, ext_pin, pb, slow, ret_cmd, sleep_cmd, addr, wdata, t0, pa, port} = '0;
		void'($urandom(32'h7999));
		k = $urandom % 8;
		rpc = 13'h1000 | 13'($urandom);
		tick(3);
		rst_n <= 1'b1;
		tick(1);
		bus(1, 8'h3f, 8'hff);
		for (int i = 0; i < 9; i++) bus(0, ri[i], rv[i]);
		// falling edge selected: the first rising edge must not count
		bus(1, IDX_TIMER_EDGE_OPT, 8'hbf);
		ext_pin <= 1'b1;
		t0 <= 8'hff;
		tick(2);
		t0 <= 8'h00;
		port <= 4'($urandom) | 4'h1;
		tick(2);
		bus(0, IDX_IRQ_CONTROL, 8'h05);
		ext_pin <= 1'b0;
		pa <= 8'h1 << k;
		pb <= 1'b1;
		tick(1);
		pa <= 8'h00;
		pb <= 1'b0;
		tick(2);
		bus(0, IDX_IRQ_CONTROL, 8'h07);
		bus(0, IDX_PERIPH_FLAG_A, 8'h1 << k);
		bus(0, IDX_PERIPH_FLAG_B, 8'h01);
		pa <= 8'h1 << k;
		bus(1, IDX_PERIPH_FLAG_A, 8'h00);
		bus(0, IDX_PERIPH_FLAG_A, 8'h1 << k);
		pa <= 8'h00;
		bus(1, IDX_PERIPH_FLAG_A, 8'h00);
		bus(1, IDX_IRQ_CONTROL, 8'h00);
		bus(1, IDX_PERIPH_ENABLE_A, 8'h1 << k);
		pa <= 8'h1 << k;
		tick(1);
		pa <= 8'h00;
		bus(1, IDX_IRQ_CONTROL, 8'h80);
		tick(4);
		lvl(irq_req, 1'b0);
		pc_q.push_back(IRQ_VECTOR);
		bus(1, IDX_IRQ_CONTROL, 8'hc0);
		drain();
		bus(0, IDX_IRQ_CONTROL, 8'h40);
		bus(0, IDX_PERIPH_FLAG_A, 8'h1 << k);
		bus(0, IDX_EVENT_STATUS, 8'h01);
		bus(1, IDX_EVENT_MASK, 8'h01);
		tick(2);
		lvl(irq, 1'b1);
		bus(1, IDX_EVENT_MASK, 8'h00);
		tick(2);
		lvl(irq, 1'b0);
		bus(1, IDX_EVENT_MASK, 8'h01);
		bus(1, IDX_EVENT_STATUS, 8'h01);
		tick(2);
		lvl(irq, 1'b0);
		bus(1, IDX_PERIPH_FLAG_A, 8'h00);
		pc_q.push_back(rpc);
		ret_cmd <= 1'b1;
		tick(1);
		ret_cmd <= 1'b0;
		drain();
		bus(0, IDX_IRQ_CONTROL, 8'hc0);
		bus(0, IDX_EVENT_STATUS, 8'h04);
		bus(1, IDX_IRQ_CONTROL, 8'h40);
		bus(0, IDX_IRQ_CONTROL, 8'h40);
		// slow core, then sleep with the pin enabled and global enable clear
		slow <= 1'b1;
		ext_pin <= 1'b1;
		bus(1, IDX_IRQ_CONTROL, 8'h50);
		sleep_cmd <= 1'b1;
		tick(1);
		sleep_cmd <= 1'b0;
		tick(3);
		lvl(sleeping, 1'b1);
		bus(0, IDX_CORE_STATE, 8'h01);
		ext_pin <= 1'b0;
		for (int i = 0; i < 20 && wake !== 1'b1; i++) @(posedge clk);
		lvl(wake, 1'b1);
		tick(2);
		lvl(sleeping, 1'b0);
		bus(0, IDX_EVENT_STATUS, 8'h06);
		bus(0, IDX_IRQ_CONTROL, 8'h52);
		bus(1, IDX_IRQ_CONTROL, 8'h82);
		tick(6);
		lvl(irq_req, 1'b0);
		pc_q.push_back(IRQ_VECTOR);
		bus(1, IDX_IRQ_CONTROL, 8'h92);
		drain();
		bus(0, IDX_CORE_STATE, 8'h04);
		// mid-run reset with global enable set; port pins stay off zero
		bus(1, IDX_IRQ_CONTROL, 8'h80);
		rst_n <= 1'b0;
		tick(2);
		rst_n <= 1'b1;
		tick(1);
		bus(0, IDX_IRQ_CONTROL, 8'h00);
		bus(0, IDX_CORE_STATE, 8'h00);
		bus(0, IDX_EVENT_STATUS, 8'h00);
		complete_run();
	end
endmodule
